// *** shared/dspfi_consts.svh ***
// offsets, field positions, reset values and timing counts for the flag init sequencer
`ifndef DSPFI_CONSTS_SVH
`define DSPFI_CONSTS_SVH
`define DSPFI_OFF_CLKSTCTRL   12'h000
`define DSPFI_OFF_CLKCTRL     12'h004
`define DSPFI_OFF_RSTCTRL     12'h008
`define DSPFI_OFF_PWRSTCTRL   12'h00c
`define DSPFI_OFF_EMUSTCTRL   12'h010
`define DSPFI_OFF_STATUS      12'h014
`define DSPFI_DOM_FORCED_SOFTWARE_WAKEUP     2'h2
`define DSPFI_DOM_HARDWARE_AUTO_GATING     2'h3
`define DSPFI_MOD_ENABLE      2'h1
`define DSPFI_RST_RELEASE     2'h1
`define DSPFI_RST_ASSERT      2'h3
`define DSPFI_IDLEST_LSB      16
`define DSPFI_IDLEST_DISABLED 2'h3
`define DSPFI_IDLEST_FUNC     2'h0
`define DSPFI_RST_CLKSTCTRL   2'h0
`define DSPFI_RST_CLKCTRL     2'h0
`define DSPFI_RST_RSTCTRL     2'h3
`define DSPFI_RST_PWRSTCTRL   32'h00000000
`define DSPFI_RST_EMUSTCTRL   2'h3
`define DSPFI_CLK_MHZ         40
`define DSPFI_WAKE_NS         200
`define DSPFI_WAKE_CYC        ((`DSPFI_WAKE_NS * `DSPFI_CLK_MHZ + 999) / 1000)
`define DSPFI_EMU_DIV         4
`endif

// *** shared/dspfi_pkg.sv ***
// types for the flag init sequencer
package dspfi_pkg;
  typedef enum logic [3:0] {
    DSPFI_OFF    = 4'h1,
    DSPFI_WAKING = 4'h2,
    DSPFI_FUNC   = 4'h4,
    DSPFI_STBY   = 4'h8
  } dspfi_state_t;
endpackage

// *** verilog/dspfi_emu_clk.sv ***
// emulation clock gate: free running under debugger or forced wakeup
`timescale 1ns/1ps
`include "dspfi_consts.svh"
module dspfi_emu_clk (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic [1:0] emu_mode,
  input  wire logic       debugger_attached,
  // result
  output logic            emu_clk_running
);
  logic [1:0] dbg_sync_q;
  logic       run_q;
  // debugger attach comes from a pin outside this clock domain; two stages before any use
  wire        run_d = dbg_sync_q[1] || (emu_mode == `DSPFI_DOM_FORCED_SOFTWARE_WAKEUP);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_sync_q <= 2'h0;
      run_q      <= 1'b0;
    end else begin
      dbg_sync_q <= {dbg_sync_q[0], debugger_attached};
      run_q      <= run_d;
    end
  end
  // a debugger attach is seen three cycles late, which delays standby entry and the emu_run status bit
  assign emu_clk_running = run_q;
  AST_EMU_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    (emu_mode == `DSPFI_DOM_FORCED_SOFTWARE_WAKEUP) |=> emu_clk_running) else $error("emu clock not running");
endmodule // dspfi_emu_clk

// *** verilog/dspfi_seq.sv ***
// power, clock and reset control of the signal processor subsystem with flag init
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "dspfi_consts.svh"
module dspfi_seq (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // subsystem side
  input  wire logic        debugger_attached,
  input  wire logic        idle_request,
  output logic             arbitration_priority_flag,
  output logic             initiator_standby_handshake,
  output logic             sp_clock_on,
  output logic             sp_reset_n
);
  logic [1:0]  dom_q;
  logic [1:0]  mod_q;
  logic [1:0]  rst_q;
  logic [31:0] pwr_q;
  logic [1:0]  emu_q;
  logic        err_q;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  logic        flag_q;
  logic        stby_q;
  logic [31:0] rdata_q;
  logic        ready_q;
  logic        slverr_q;
  logic [31:0] pwr_d;
  logic        clk_on_q;
  logic        sp_rst_n_q;
  logic        emu_run;
  dspfi_pkg::dspfi_state_t st_q;
  dspfi_pkg::dspfi_state_t st_d;

  wire setup   = psel && !penable;
  // writes land at the access edge, where the master sees pready high
  wire wr      = psel && penable && ready_q && pwrite && (pstrb[0] || pstrb[1] || pstrb[2] || pstrb[3]);
  wire hit_dom = paddr == `DSPFI_OFF_CLKSTCTRL;
  wire hit_mod = paddr == `DSPFI_OFF_CLKCTRL;
  wire hit_rst = paddr == `DSPFI_OFF_RSTCTRL;
  wire hit_pwr = paddr == `DSPFI_OFF_PWRSTCTRL;
  wire hit_emu = paddr == `DSPFI_OFF_EMUSTCTRL;
  wire hit_sts = paddr == `DSPFI_OFF_STATUS;
  wire mapped  = hit_dom || hit_mod || hit_rst || hit_pwr || hit_emu || hit_sts;
  wire lo_byte = pstrb[0];
  wire clk_req = (mod_q == `DSPFI_MOD_ENABLE) || (dom_q == `DSPFI_DOM_FORCED_SOFTWARE_WAKEUP);
  wire out_rst = rst_q == `DSPFI_RST_RELEASE;
  wire active  = (st_q == dspfi_pkg::DSPFI_FUNC) || (st_q == dspfi_pkg::DSPFI_STBY);
  // idle status: 0 functional or standby, 3 disabled, 1 in transition
  wire [1:0] idlest = active ? `DSPFI_IDLEST_FUNC :
                      (st_q == dspfi_pkg::DSPFI_WAKING) ? 2'h1 : `DSPFI_IDLEST_DISABLED;
  wire [31:0] mod_rd = {14'h0000, idlest, 14'h0000, mod_q};
  wire [31:0] rd_mux = hit_dom ? {30'h0, dom_q} :
                       hit_mod ? mod_rd :
                       hit_rst ? {30'h0, rst_q} :
                       hit_pwr ? pwr_q :
                       hit_emu ? {30'h0, emu_q} :
                       hit_sts ? {29'h0, emu_run, flag_q, err_q} : 32'h00000000;
  // standby is entered only with a toggling emulation clock; otherwise the request is held off
  wire stby_ok = idle_request && emu_run;

  // power state keeps whatever software wrote back; byte lanes follow the strobes
  for (genvar g = 0; g < 4; g++) begin : g_pwr_lane
    assign pwr_d[8*g +: 8] = (wr && hit_pwr && pstrb[g]) ? pwdata[8*g +: 8] : pwr_q[8*g +: 8];
  end

  dspfi_emu_clk u_emu (
    .pclk              (pclk),
    .presetn           (presetn),
    .emu_mode          (emu_q),
    .debugger_attached (debugger_attached),
    .emu_clk_running   (emu_run)
  );

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      dspfi_pkg::DSPFI_OFF: begin
        cnt_d = 4'h0;
        if (clk_req && out_rst) begin
          st_d = dspfi_pkg::DSPFI_WAKING;
        end
      end
      dspfi_pkg::DSPFI_WAKING: begin
        // fixed short wakeup, far inside any software timeout
        cnt_d = cnt_q + 4'h1;
        if (!(clk_req && out_rst)) begin
          st_d = dspfi_pkg::DSPFI_OFF;
        end else if (cnt_q == 4'(`DSPFI_WAKE_CYC - 1)) begin
          st_d = dspfi_pkg::DSPFI_FUNC;
        end
      end
      dspfi_pkg::DSPFI_FUNC: begin
        if (!(clk_req && out_rst)) begin
          st_d = dspfi_pkg::DSPFI_OFF;
        end else if (stby_ok) begin
          st_d = dspfi_pkg::DSPFI_STBY;
        end
      end
      dspfi_pkg::DSPFI_STBY: begin
        if (!(clk_req && out_rst)) begin
          st_d = dspfi_pkg::DSPFI_OFF;
        end else if (!idle_request) begin
          st_d = dspfi_pkg::DSPFI_FUNC;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= dspfi_pkg::DSPFI_OFF;
      cnt_q <= 4'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // registers; zero wait states, so a write lands one edge after its setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dom_q <= `DSPFI_RST_CLKSTCTRL;
      mod_q <= `DSPFI_RST_CLKCTRL;
      rst_q <= `DSPFI_RST_RSTCTRL;
      pwr_q <= `DSPFI_RST_PWRSTCTRL;
      emu_q <= `DSPFI_RST_EMUSTCTRL;
      err_q <= 1'b0;
    end else begin
      if (wr && hit_dom && lo_byte) dom_q <= pwdata[1:0];
      if (wr && hit_mod && lo_byte) mod_q <= pwdata[1:0];
      if (wr && hit_rst && lo_byte) rst_q <= pwdata[1:0];
      pwr_q <= pwr_d;
      if (wr && hit_emu && lo_byte) emu_q <= pwdata[1:0];
      // software logs a timeout here; write 1 sets, write 0 clears
      if (wr && hit_sts && lo_byte) err_q <= pwdata[0];
    end
  end

  // flag is undefined in the real part before first clocking; here it resets to 1 to show that
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q     <= 1'b1;
      stby_q     <= 1'b0;
      clk_on_q   <= 1'b0;
      sp_rst_n_q <= 1'b0;
    end else begin
      if (active) flag_q <= 1'b0;
      stby_q     <= st_q == dspfi_pkg::DSPFI_STBY;
      // taken from the next state so the pin tracks the state register without lag
      clk_on_q   <= (st_d == dspfi_pkg::DSPFI_FUNC) || (st_d == dspfi_pkg::DSPFI_STBY);
      sp_rst_n_q <= out_rst;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q  <= 32'h00000000;
      ready_q  <= 1'b0;
      slverr_q <= 1'b0;
    end else begin
      ready_q  <= setup;
      slverr_q <= setup && !mapped;
      rdata_q  <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  assign prdata                      = rdata_q;
  assign pready                      = ready_q;
  assign pslverr                     = slverr_q;
  assign arbitration_priority_flag   = flag_q;
  assign initiator_standby_handshake = stby_q;
  assign sp_clock_on                 = clk_on_q;
  assign sp_reset_n                  = sp_rst_n_q;

  AST_FLAG_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == dspfi_pkg::DSPFI_FUNC) |=> !arbitration_priority_flag) else $error("flag not zero");
  AST_FUNC_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == dspfi_pkg::DSPFI_WAKING) && clk_req && out_rst |-> ##[0:8] active || !(clk_req && out_rst))
    else $error("functional too late");
  sequence s_running;
    active && clk_req && out_rst;
  endsequence
  sequence s_dropped;
    !(clk_req && out_rst);
  endsequence
  AST_DROP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    s_running ##1 s_dropped |=> (st_q == dspfi_pkg::DSPFI_OFF) && !arbitration_priority_flag)
    else $error("not off with flag low after disable");
  AST_STBY_EMU: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_q == dspfi_pkg::DSPFI_STBY) |-> $past(emu_run)) else $error("standby without emu clock");
  AST_OFF_ON_RST: assert property (@(posedge pclk) disable iff (!presetn)
    (rst_q == `DSPFI_RST_ASSERT) |=> (st_q == dspfi_pkg::DSPFI_OFF)) else $error("not off in reset");
endmodule // dspfi_seq

// *** sim/tb_dsp_flag_init_power_sequence.sv ***
// self-checking bench for the flag init sequencer over apb
`timescale 1ns/1ps
module tb_dsp_flag_init_power_sequence;
  logic        pclk, presetn, psel, penable, pwrite, dbg, idle_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, pwr_m;
  logic [3:0]  pstrb;
  logic        pready, pslverr, flag, stby, clk_on, sp_rst_n, rerr;
  int          err_total, n_checks, seed, k, n;

  dspfi_seq dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .debugger_attached(dbg), .idle_request(idle_req),
    .arbitration_priority_flag(flag), .initiator_standby_handshake(stby),
    .sp_clock_on(clk_on), .sp_reset_n(sp_rst_n));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // hold the request until pready is seen high; the bench timeout ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0; pstrb <= 4'h0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp);
    chk_bit(rerr, eerr);
  endtask

  initial begin
    #(25ns * 20000);
    err_total++;
    complete_run();
  end

  initial begin
    seed = 18241;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0;
    dbg = 1'b0; idle_req = 1'b0; presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h000, 32'h0, 1'b0);
    rdchk(12'h004, 32'h00030000, 1'b0);
    rdchk(12'h008, 32'h3, 1'b0);
    rdchk(12'h010, 32'h3, 1'b0);
    rdchk(12'h01c, 32'h0, 1'b1);
    pwr_m = $random(seed);
    apb(1'b1, 12'h00c, pwr_m);
    rdchk(12'h00c, pwr_m, 1'b0);
    apb(1'b1, 12'h014, 32'h1);
    rdchk(12'h014, 32'h3, 1'b0);
    apb(1'b1, 12'h014, 32'h0);
    // second pass starts from a fresh reset so the flag is high again before it is cleared
    for (k = 0; k < 2; k++) begin
      if (k == 1) begin
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk_bit(flag, 1'b1);
        pwr_m = $random(seed);
        apb(1'b1, 12'h00c, pwr_m);
      end
      apb(1'b1, 12'h000, 32'h2);
      apb(1'b1, 12'h004, 32'h1);
      apb(1'b1, 12'h008, 32'h1);
      n = 0;
      do begin
        apb(1'b0, 12'h004, 32'h0);
        n++;
      end while ((rd & 32'h00030000) != 32'h0 && n < 40);
      if ((rd & 32'h00030000) != 32'h0)
        apb(1'b1, 12'h014, 32'h1);
      chk_word(rd & 32'h00030000, 32'h0);
      chk_bit(flag, 1'b0);
      chk_bit(clk_on, 1'b1);
      chk_bit(sp_rst_n, 1'b1);
      idle_req <= 1'b1;
      repeat (4) @(posedge pclk);
      chk_bit(stby, 1'b0);
      if (k == 0)
        dbg <= 1'b1;
      else
        apb(1'b1, 12'h010, 32'h2);
      repeat (8) @(posedge pclk);
      chk_bit(stby, 1'b1);
      idle_req <= 1'b0;
      dbg <= 1'b0;
      apb(1'b1, 12'h000, 32'h3);
      apb(1'b0, 12'h00c, 32'h0);
      apb(1'b1, 12'h00c, rd & 32'hffffffff);
      rdchk(12'h00c, pwr_m, 1'b0);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h008, 32'h3);
      apb(1'b1, 12'h010, 32'h3);
      repeat (2) @(posedge pclk);
      chk_bit(flag, 1'b0);
      chk_bit(sp_rst_n, 1'b0);
      chk_bit(clk_on, 1'b0);
      rdchk(12'h004, 32'h00030000, 1'b0);
      rdchk(12'h014, 32'h0, 1'b0);
    end
    complete_run();
  end
endmodule // tb_dsp_flag_init_power_sequence
